//--- eth_bd_dma.sv
// Buffer-descriptor DMA of the ethernet_controller: APB registers, AHB master.
// Assumes packet buffer and transmitter run on clk_sys; single-word AHB transfers.
//
// Summary of operation
// - Receive buffer size 64B..16KB, default 128B
// - Receive descriptor is address word plus status
// - Word 0 bits 31:2 give buffer address
// - Word 0 bit 1 marks last descriptor
// - Write only unowned buffers, then set bit 0
// - Non-final buffer status zero except start flag
// - Fetch next descriptor; final status holds frame
// - Status bits 31,30,29: broadcast, multicast, unicast
// - Frame check sequence kept or dropped by config
// - Partial forward waits for programmable watermark
// - Separate transmit and receive descriptor lists
// - Receive fetch starts at programmed queue base
// - Transmit buffer 1..2047 bytes, 128 per frame
`timescale 1ns/1ps
`default_nettype none
`include "eth_bd_dma_consts.svh"

module eth_bd_dma
  import eth_bd_dma_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  output logic [31:0] haddr, // AHB address
  output logic [1:0] htrans, // AHB transfer type
  output logic hwrite, // AHB write
  output logic [2:0] hsize, // AHB size, word
  output logic [2:0] hburst, // AHB burst, single
  output logic [31:0] hwdata, // AHB write data
  input wire logic [31:0] hrdata, // AHB read data
  input wire logic hready, // AHB ready
  input wire rx_word_s rx_in, // Receive word stream
  output logic rx_ready, // Receive word taken
  input wire logic [11:0] rx_stored, // Words held in packet buffer
  input wire logic rx_complete, // Whole frame held
  output tx_word_s tx_out, // Transmit word stream
  input wire logic tx_ready, // Transmit word taken
  output logic loopback, // Loopback mode
  output logic tx_psf_en, // Transmit partial forward
  output logic [11:0] tx_psf_wm // Transmit watermark
);

  //////////////////////////////////////////////////////////////////////////
  // State
  dma_state_s r_reg; // All state
  dma_state_s r_next; // Next state
  logic done; // AHB data phase finished
  logic go; // Start an AHB transfer
  logic [31:0] go_addr; // Its address
  logic go_wr; // Its direction
  logic [31:0] go_data; // Its write data
  logic [31:0] rd; // APB read mux
  logic rd_err; // Unmapped read or write
  logic [8:0] bufsz_eff; // Clamped buffer size units
  logic [14:0] buf_bytes; // Buffer size in bytes
  logic [31:0] rx_stat; // Status word being built

  //////////////////////////////////////////////////////////////////////////
  // Buffer size in 64-byte units; zero and oversize clamped
  always_comb
  begin
    if (r_reg.bufsz == 9'h000)
      bufsz_eff = 9'h001;
    else if (r_reg.bufsz > `BUFSZ_MAX)
      bufsz_eff = `BUFSZ_MAX;
    else
      bufsz_eff = r_reg.bufsz;
    buf_bytes = {bufsz_eff[8:0], 6'h00};
  end

  //////////////////////////////////////////////////////////////////////////
  // Register read mux
  always_comb
  begin
    rd = 32'h0;
    rd_err = 1'b0;
    case (paddr)
      `OFF_CTRL:
      begin
        rd[`CTRL_LOOP] = r_reg.loop;
        rd[`CTRL_RXEN] = r_reg.rx_en;
        rd[`CTRL_TXEN] = r_reg.tx_en;
      end
      `OFF_STAT:
      begin
        rd[`STAT_NOBUF] = r_reg.rx_nobuf;
        rd[`STAT_TXERR] = r_reg.tx_err;
        rd[`STAT_TXGO] = r_reg.tx_go;
        rd[`STAT_BUSY] = (r_reg.st != S_IDLE);
      end
      `OFF_DCFG:
      begin
        rd[`DCFG_BUFSZ_LSB +: 9] = r_reg.bufsz;
        rd[`DCFG_STRIP] = r_reg.strip;
      end
      `OFF_RXQ: rd = r_reg.rxq; // Shows current descriptor
      `OFF_TXQ: rd = r_reg.txq;
      `OFF_PSF_RX: rd = {r_reg.psf_rx_en, 19'h0, r_reg.rx_wm};
      `OFF_PSF_TX: rd = {r_reg.psf_tx_en, 19'h0, r_reg.tx_wm};
      default: rd_err = 1'b1; // Unmapped: zero data, error
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state: APB slave, AHB phase tracker, engine
  always_comb
  begin
    r_next = r_reg;
    go = 1'b0;
    go_addr = 32'h0;
    go_wr = 1'b0;
    go_data = 32'h0;
    rx_ready = 1'b0;
    rx_stat = 32'h0;
    done = (r_reg.ph == 2'd2) && hready;
    // AHB address phase then data phase
    case (r_reg.ph)
      2'd1:
        if (hready)
        begin
          r_next.htrans = `HTRANS_IDLE;
          r_next.ph = 2'd2;
        end
      2'd2:
        if (hready)
          r_next.ph = 2'd0;
      default: ;
    endcase
    // APB setup captures read data so it comes from flops
    if (psel && !penable)
    begin
      r_next.prdata = rd;
      r_next.pslverr = rd_err;
    end
    if (psel && penable && pwrite)
    begin
      case (paddr)
        `OFF_CTRL:
        begin
          r_next.loop = pwdata[`CTRL_LOOP];
          r_next.rx_en = pwdata[`CTRL_RXEN];
          r_next.tx_en = pwdata[`CTRL_TXEN];
          if (pwdata[`CTRL_TXGO])
            r_next.tx_go = 1'b1;
        end
        `OFF_STAT:
        begin
          // Write one to clear; hardware set below wins
          if (pwdata[`STAT_NOBUF])
            r_next.rx_nobuf = 1'b0;
          if (pwdata[`STAT_TXERR])
            r_next.tx_err = 1'b0;
        end
        `OFF_DCFG:
        begin
          r_next.bufsz = pwdata[`DCFG_BUFSZ_LSB +: 9];
          r_next.strip = pwdata[`DCFG_STRIP];
        end
        `OFF_RXQ:
        begin
          r_next.rxq_base = {pwdata[31:2], 2'b00};
          r_next.rxq = {pwdata[31:2], 2'b00};
        end
        `OFF_TXQ:
        begin
          r_next.txq_base = {pwdata[31:2], 2'b00};
          r_next.txq = {pwdata[31:2], 2'b00};
        end
        `OFF_PSF_RX:
        begin
          r_next.psf_rx_en = pwdata[`PSF_EN];
          r_next.rx_wm = pwdata[11:0];
        end
        `OFF_PSF_TX:
        begin
          r_next.psf_tx_en = pwdata[`PSF_EN];
          r_next.tx_wm = pwdata[11:0];
        end
        default: ;
      endcase
    end
    if (r_reg.txo.valid && tx_ready)
      r_next.txo.valid = 1'b0;
    // Engine; one transfer at a time, receive first
    case (r_reg.st)
      S_IDLE:
      begin
        // Partial forward waits for the watermark or a whole frame
        if (r_reg.rx_en && rx_in.valid && (!r_reg.psf_rx_en ||
            rx_stored >= r_reg.rx_wm || rx_complete))
        begin
          r_next.st = S_RXD0;
          r_next.sof = 1'b1;
          r_next.flen = 13'h0;
          r_next.last = 1'b0;
        end
        else if (r_reg.tx_en && r_reg.tx_go)
        begin
          r_next.st = S_TXD0;
          r_next.tbufs = 8'h0;
          r_next.last = 1'b0; // Receive end leaves it set; would block fetch
        end
      end
      S_RXD0:
      begin
        go = (r_reg.ph == 2'd0);
        go_addr = r_reg.rxq;
        if (done)
        begin
          if (hrdata[`D0_OWN])
          begin
            // Owned by software: flag it and retry from idle
            r_next.rx_nobuf = 1'b1;
            r_next.st = S_IDLE;
          end
          else
          begin
            r_next.w0 = hrdata;
            r_next.bcnt = 15'h0;
            r_next.st = S_RXDAT;
          end
        end
      end
      S_RXDAT:
      begin
        if (r_reg.ph == 2'd0 && rx_in.valid)
        begin
          rx_ready = 1'b1;
          if (rx_in.last)
            r_next.flags = {rx_in.bcast, rx_in.mcast, rx_in.ucast};
          if (rx_in.fcs && r_reg.strip)
          begin
            if (rx_in.last)
            begin
              r_next.last = 1'b1;
              r_next.st = S_RXST;
            end
          end
          else
          begin
            go = 1'b1;
            go_wr = 1'b1;
            go_addr = {r_reg.w0[31:2], 2'b00} + {17'h0, r_reg.bcnt};
            go_data = rx_in.data;
            r_next.last = rx_in.last;
          end
        end
        if (done)
        begin
          r_next.bcnt = r_reg.bcnt + 15'h4;
          r_next.flen = r_reg.flen + 13'h4;
          if (r_reg.last || (r_reg.bcnt + 15'h4 == buf_bytes))
            r_next.st = S_RXST;
        end
      end
      S_RXST:
      begin
        // Non-final buffers: zero except start flag
        rx_stat[`RXS_SOF] = r_reg.sof;
        if (r_reg.last)
        begin
          rx_stat[`RXS_BCAST] = r_reg.flags[2];
          rx_stat[`RXS_MCAST] = r_reg.flags[1];
          rx_stat[`RXS_UCAST] = r_reg.flags[0];
          rx_stat[`RXS_EOF] = 1'b1;
          rx_stat[12:0] = r_reg.flen;
        end
        go = (r_reg.ph == 2'd0);
        go_wr = 1'b1;
        go_addr = r_reg.rxq + 32'h4;
        go_data = rx_stat;
        if (done)
          r_next.st = S_RXOWN;
      end
      S_RXOWN:
      begin
        // Ownership set last so software never sees a stale status
        go = (r_reg.ph == 2'd0);
        go_wr = 1'b1;
        go_addr = r_reg.rxq;
        go_data = {r_reg.w0[31:1], 1'b1};
        if (done)
        begin
          r_next.rxq = r_reg.w0[`D0_WRAP] ? r_reg.rxq_base
                                          : r_reg.rxq + 32'h8;
          r_next.sof = 1'b0;
          r_next.st = r_reg.last ? S_IDLE : S_RXD0;
        end
      end
      S_TXD0:
      begin
        go = (r_reg.ph == 2'd0);
        go_addr = r_reg.txq;
        if (done)
        begin
          r_next.w0 = hrdata;
          r_next.st = S_TXD1;
        end
      end
      S_TXD1:
      begin
        go = (r_reg.ph == 2'd0);
        go_addr = r_reg.txq + 32'h4;
        if (done)
        begin
          r_next.w1 = hrdata;
          r_next.rem = hrdata[10:0];
          r_next.bcnt = 15'h0;
          if (hrdata[`TXD_USED])
          begin
            // Used descriptor ends transmission
            r_next.tx_go = 1'b0;
            r_next.st = S_IDLE;
          end
          else if (hrdata[10:0] == 11'h0 || r_reg.tbufs == `TX_MAX_BUFS)
          begin
            r_next.tx_err = 1'b1;
            r_next.tx_go = 1'b0;
            r_next.st = S_IDLE;
          end
          else
            r_next.st = S_TXDAT;
        end
      end
      S_TXDAT:
      begin
        go = (r_reg.ph == 2'd0) && !r_reg.txo.valid && !r_reg.last;
        go_addr = {r_reg.w0[31:2], 2'b00} + {17'h0, r_reg.bcnt};
        if (done)
        begin
          r_next.txo.valid = 1'b1;
          r_next.txo.data = hrdata;
          r_next.txo.last = r_reg.w1[`TXD_LAST] && (r_reg.rem <= 11'h4);
          r_next.last = (r_reg.rem <= 11'h4);
          r_next.rem = r_reg.rem - 11'h4;
          r_next.bcnt = r_reg.bcnt + 15'h4;
        end
        // Move on only once the last word is taken
        if (r_reg.last && r_reg.txo.valid && tx_ready)
        begin
          r_next.last = 1'b0;
          r_next.st = S_TXWB;
        end
      end
      S_TXWB:
      begin
        go = (r_reg.ph == 2'd0);
        go_wr = 1'b1;
        go_addr = r_reg.txq + 32'h4;
        go_data = r_reg.w1 | 32'h80000000;
        if (done)
        begin
          r_next.txq = r_reg.w1[`TXD_WRAP] ? r_reg.txq_base
                                           : r_reg.txq + 32'h8;
          r_next.tbufs = r_reg.tbufs + 8'h1;
          r_next.st = r_reg.w1[`TXD_LAST] ? S_IDLE : S_TXD0;
        end
      end
      default: r_next.st = S_IDLE;
    endcase
    if (go)
    begin
      r_next.ph = 2'd1;
      r_next.htrans = `HTRANS_NONSEQ;
      r_next.haddr = go_addr;
      r_next.hwrite = go_wr;
      r_next.hwdata = go_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      r_reg <= '0;
      r_reg.st <= S_IDLE;
      r_reg.bufsz <= `RST_BUFSZ;
    end
    else
      r_reg <= r_next;
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata = r_reg.prdata;
  assign pready = 1'b1; // Zero wait states
  assign pslverr = r_reg.pslverr;
  assign haddr = r_reg.haddr;
  assign htrans = r_reg.htrans;
  assign hwrite = r_reg.hwrite;
  assign hsize = `HSIZE_WORD;
  assign hburst = `HBURST_SINGLE;
  assign hwdata = r_reg.hwdata;
  assign tx_out = r_reg.txo;
  assign loopback = r_reg.loop;
  assign tx_psf_en = r_reg.psf_tx_en;
  assign tx_psf_wm = r_reg.tx_wm;

endmodule : eth_bd_dma
`default_nettype wire

//--- eth_bd_dma_chk.sv
// Checker of the descriptor DMA ports: APB, AHB master and word streams.
// Assumes it is bound to eth_bd_dma and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "eth_bd_dma_consts.svh"
module eth_bd_dma_chk
  import eth_bd_dma_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic resetn, // Reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB address
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB type
  input wire logic hready, // AHB ready
  input wire logic [2:0] hsize, // AHB size
  input wire logic [2:0] hburst, // AHB burst
  input wire rx_word_s rx_in, // Receive stream
  input wire logic rx_ready, // Receive take
  input wire tx_word_s tx_out, // Transmit stream
  input wire logic tx_ready, // Transmit take
  input wire logic loopback // Loopback mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  AST_AHB_FIXED: assert property (hsize == `HSIZE_WORD && hburst == `HBURST_SINGLE)
    else $error("AHB size or burst not single word");
  AST_ZERO_WAIT: assert property (psel && penable |-> pready)
    else $error("APB access not zero wait");
  AST_ADDR_HOLD: assert property (htrans == `HTRANS_NONSEQ && !hready |=>
    htrans == `HTRANS_NONSEQ && $stable(haddr)) else $error("AHB address dropped in stall");
  AST_ALIGN: assert property (htrans == `HTRANS_NONSEQ |-> haddr[1:0] == 2'b00)
    else $error("AHB address not word aligned");
  AST_SINGLE: assert property (htrans == `HTRANS_NONSEQ && hready |=>
    htrans == `HTRANS_IDLE) else $error("AHB transfers overlap");
  AST_TX_HOLD: assert property (tx_out.valid && !tx_ready |=>
    tx_out.valid && $stable(tx_out.data)) else $error("Transmit word not held");
  AST_RX_TAKE: assert property (rx_ready |-> rx_in.valid)
    else $error("Receive take without word");
  AST_UNMAPPED: assert property (psel && penable && !(paddr inside {`OFF_CTRL,
    `OFF_STAT, `OFF_DCFG, `OFF_RXQ, `OFF_TXQ, `OFF_PSF_RX, `OFF_PSF_TX}) |-> pslverr)
    else $error("Unmapped access without error");
  AST_LOOP: assert property (!(psel && penable && pwrite && paddr == `OFF_CTRL) |=>
    $stable(loopback)) else $error("Loopback changed without control write");
endmodule : eth_bd_dma_chk
`default_nettype wire

//--- eth_bd_dma_consts.svh
// Offsets, field positions, reset values and counts of the descriptor DMA.
// Included by the package and the DMA module; definitions only.
`ifndef ETH_BD_DMA_CONSTS_SVH
`define ETH_BD_DMA_CONSTS_SVH
// Register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STAT 12'h004
`define OFF_DCFG 12'h010
`define OFF_RXQ 12'h018
`define OFF_TXQ 12'h01c
`define OFF_PSF_RX 12'h020
`define OFF_PSF_TX 12'h024
// Control bits
`define CTRL_LOOP 1
`define CTRL_RXEN 2
`define CTRL_TXEN 3
`define CTRL_TXGO 9
// Status bits
`define STAT_NOBUF 0
`define STAT_TXERR 1
`define STAT_TXGO 2
`define STAT_BUSY 3
// DMA config fields
`define DCFG_BUFSZ_LSB 16
`define DCFG_STRIP 10
`define RST_BUFSZ 9'h002
`define BUFSZ_MAX 9'h100
// Watermark registers: level in low bits, enable on top
`define PSF_EN 31
// Descriptor fields
`define D0_OWN 0
`define D0_WRAP 1
`define RXS_BCAST 31
`define RXS_MCAST 30
`define RXS_UCAST 29
`define RXS_EOF 15
`define RXS_SOF 14
`define TXD_USED 31
`define TXD_WRAP 30
`define TXD_LAST 15
`define TX_MAX_BUFS 8'h80
// AHB encodings
`define HTRANS_IDLE 2'b00
`define HTRANS_NONSEQ 2'b10
`define HSIZE_WORD 3'b010
`define HBURST_SINGLE 3'b000
`endif

//--- eth_bd_dma_mem.sv
// AHB system memory model facing the DMA master port.
// Assumes single NONSEQ word transfers; slow inserts wait states.
`timescale 1ns/1ps
`default_nettype none
module eth_bd_dma_mem
(
  input wire logic clk_sys, // Clock
  input wire logic resetn, // Reset, low
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic slow, // Wait states on
  output logic [31:0] hrdata, // Read data
  output logic hready // Ready
);
  logic [31:0] mem [0:1023]; // Descriptors and buffers, one word each entry
  logic dp; // Data phase pending
  logic dw; // Data phase writes
  logic [9:0] da; // Data phase word index
  logic [7:0] cnt; // Free-running count
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Stalls every other cycle when slow, so hold logic is exercised
  assign hready = !slow || cnt[0];
  // Moving pattern outside data phase; stale data would hide bugs
  assign hrdata = dp ? mem[da] : {4{cnt}};
  // Address phase captured, data phase completed on hready
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      dp <= 1'b0;
      cnt <= 8'h00;
    end
    else
    begin
      cnt <= cnt + 8'h01;
      if (hready)
      begin
        if (dp && dw)
          mem[da] <= hwdata;
        dp <= htrans == 2'b10;
        dw <= hwrite;
        da <= haddr[11:2];
      end
    end
  end
endmodule : eth_bd_dma_mem
`default_nettype wire

//--- eth_bd_dma_pkg.sv
// Types shared by the descriptor DMA and its surroundings.
// Assumes the constants header sits in the same folder.
`include "eth_bd_dma_consts.svh"
package eth_bd_dma_pkg;
  // One-hot engine states
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_RXD0 = 9'h002,
    S_RXDAT = 9'h004,
    S_RXST = 9'h008,
    S_RXOWN = 9'h010,
    S_TXD0 = 9'h020,
    S_TXD1 = 9'h040,
    S_TXDAT = 9'h080,
    S_TXWB = 9'h100
  } dma_state_e;
  // Word from the packet buffer toward memory
  typedef struct packed {
    logic valid;
    logic [31:0] data;
    logic last;
    logic fcs;
    logic bcast;
    logic mcast;
    logic ucast;
  } rx_word_s;
  // Word from memory toward the transmitter
  typedef struct packed {
    logic valid;
    logic [31:0] data;
    logic last;
  } tx_word_s;
  // Whole state of the engine
  typedef struct packed {
    dma_state_e st;
    logic [1:0] ph;
    logic [31:0] haddr;
    logic hwrite;
    logic [1:0] htrans;
    logic [31:0] hwdata;
    logic [31:0] prdata;
    logic pslverr;
    logic loop;
    logic rx_en;
    logic tx_en;
    logic tx_go;
    logic [8:0] bufsz;
    logic strip;
    logic psf_rx_en;
    logic [11:0] rx_wm;
    logic psf_tx_en;
    logic [11:0] tx_wm;
    logic [31:0] rxq_base;
    logic [31:0] rxq;
    logic [31:0] txq_base;
    logic [31:0] txq;
    logic rx_nobuf;
    logic tx_err;
    logic [31:0] w0;
    logic [31:0] w1;
    logic sof;
    logic last;
    logic [2:0] flags;
    logic [14:0] bcnt;
    logic [12:0] flen;
    logic [10:0] rem;
    logic [7:0] tbufs;
    tx_word_s txo;
  } dma_state_s;
endpackage : eth_bd_dma_pkg

//--- eth_bd_dma_test.sv
// Self-checking bench of the descriptor DMA with an AHB memory model.
// Assumes software setup is done through APB tasks and direct memory writes.
`timescale 1ns/1ps
`default_nettype none
`include "eth_bd_dma_consts.svh"
module eth_bd_dma_test;
  import eth_bd_dma_pkg::*;
  logic clk_sys = 1'b0; // Clock
  logic resetn = 1'b0; // Reset, low
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB control
  logic [11:0] paddr = 12'h000; // APB address
  logic [31:0] pwdata = 32'h0000_0000, prdata, hrdata, haddr, hwdata; // Data buses
  logic pready, pslverr, hwrite, hready, rx_ready, loopback, tx_psf_en; // Flags
  logic [1:0] htrans; // AHB type
  logic [2:0] hsize, hburst; // AHB fixed fields
  logic [11:0] tx_psf_wm; // Watermark out
  logic [11:0] rx_stored = 12'h000; // Stored words
  logic rx_complete = 1'b0; // Whole frame held
  logic slow = 1'b0, tx_ready = 1'b0; // Stall controls
  rx_word_s rx_in = '0; // Receive stream
  tx_word_s tx_out; // Transmit stream
  int bad_count = 0, samples_checked = 0, cycles = 0; // Counters
  eth_bd_dma i_eth_bd_dma (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hburst(hburst), .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .rx_in(rx_in),
    .rx_ready(rx_ready), .rx_stored(rx_stored), .rx_complete(rx_complete), .tx_out(tx_out),
    .tx_ready(tx_ready), .loopback(loopback), .tx_psf_en(tx_psf_en), .tx_psf_wm(tx_psf_wm));
  eth_bd_dma_mem i_eth_bd_dma_mem (.clk_sys(clk_sys), .resetn(resetn), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .slow(slow), .hrdata(hrdata),
    .hready(hready));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, stalling transmitter and hang limit
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    tx_ready <= ~tx_ready;
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer; holds the request until pready at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask : rd
  function automatic logic [31:0] m(input int i);
    return i_eth_bd_dma_mem.mem[i];
  endfunction : m
  // Bounded wait for a memory bit written back by the engine
  task automatic wait_bit(input int i, input int b);
    for (int n = 0; n < 800 && i_eth_bd_dma_mem.mem[i][b] !== 1'b1; n++)
      @(posedge clk_sys);
  endtask : wait_bit
  // Sends one frame of n words; each word held until taken
  task automatic rx_frame(input int n, input logic [31:0] base, input logic [2:0] fl,
    input logic f);
    for (int i = 0; i < n; i++)
    begin
      rx_in <= {1'b1, base + i, i == n - 1, f && i == n - 1, fl};
      for (int k = 0; k < 100; k++)
      begin
        @(posedge clk_sys);
        if (rx_ready === 1'b1)
          break;
      end
    end
    rx_in.valid <= 1'b0;
  endtask : rx_frame
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd(`OFF_DCFG, r);
    chk("dcfg reset", r, 32'h0002_0000);
    apb(1'b0, 12'h0fc, 32'h0000_0000, r, e);
    chk("unmapped data", r, 32'h0000_0000);
    chk("unmapped err", {31'h0, e}, 32'h0000_0001);
    $display("test reset done");
  endtask : t_reset
  // Two-buffer frame behind a watermark, slow memory
  task automatic t_rx_two();
    logic [31:0] r;
    int c;
    i_eth_bd_dma_mem.mem[32'h40] = 32'h0000_0400;
    i_eth_bd_dma_mem.mem[32'h42] = 32'h0000_0802;
    slow <= 1'b1;
    wr(`OFF_DCFG, 32'h0001_0000);
    wr(`OFF_RXQ, 32'h0000_0100);
    wr(`OFF_PSF_RX, 32'h8000_0008);
    rx_stored <= 12'h003;
    wr(`OFF_CTRL, 32'h0000_0004);
    rx_in <= {1'b1, 32'h1000_0000, 1'b0, 1'b0, 3'b000};
    c = 0;
    repeat (20)
    begin
      @(posedge clk_sys);
      c += int'(rx_ready === 1'b1);
    end
    chk("held below watermark", c, 0);
    rx_stored <= 12'h008;
    rx_frame(20, 32'h1000_0000, 3'b100, 1'b0);
    wait_bit(32'h42, 0);
    chk("buf0 first", m(32'h100), 32'h1000_0000);
    chk("buf0 end", m(32'h10f), 32'h1000_000f);
    chk("buf1 first", m(32'h200), 32'h1000_0010);
    chk("stat0", m(32'h41), 32'h0000_4000);
    chk("own0", m(32'h40), 32'h0000_0401);
    chk("stat1", m(32'h43), 32'h8000_8050);
    chk("own1", m(32'h42), 32'h0000_0803);
    rd(`OFF_RXQ, r);
    chk("rx pointer wrap", r, 32'h0000_0100);
    slow <= 1'b0;
    $display("test rx two buffers done");
  endtask : t_rx_two
  // Used descriptor must not take data
  task automatic t_rx_owned();
    logic [31:0] r;
    rx_in <= {1'b1, 32'h3000_0000, 1'b1, 1'b0, 3'b000};
    for (int n = 0; n < 20; n++)
    begin
      rd(`OFF_STAT, r);
      if (r[0] === 1'b1)
        break;
    end
    chk("no buffer flag", r[0], 32'h0000_0001);
    chk("buffer untouched", m(32'h100), 32'h1000_0000);
    rx_in.valid <= 1'b0;
    $display("test rx owned done");
  endtask : t_rx_owned
  // Single buffer frame with the check word stripped
  task automatic t_rx_strip();
    logic [31:0] r;
    i_eth_bd_dma_mem.mem[32'h40] = 32'h0000_0402;
    // Start comes only from the whole-frame flag, level below watermark
    rx_stored <= 12'h000;
    rx_complete <= 1'b1;
    wr(`OFF_DCFG, 32'h0001_0400);
    rx_frame(4, 32'h2000_0000, 3'b010, 1'b1);
    wait_bit(32'h40, 0);
    chk("strip data", m(32'h100), 32'h2000_0000);
    chk("strip status", m(32'h41), 32'h4000_c00c);
    wr(`OFF_STAT, 32'h0000_0001);
    rd(`OFF_STAT, r);
    chk("no buffer cleared", r[0], 32'h0000_0000);
    $display("test rx strip done");
  endtask : t_rx_strip
  // Loopback change, then a two-word transmit buffer with stalls
  task automatic t_tx();
    logic [31:0] r;
    int n;
    i_eth_bd_dma_mem.mem[32'h180] = 32'hcafe_0001;
    i_eth_bd_dma_mem.mem[32'h181] = 32'hcafe_0002;
    i_eth_bd_dma_mem.mem[32'h80] = 32'h0000_0600;
    i_eth_bd_dma_mem.mem[32'h81] = 32'h4000_8008;
    wr(`OFF_PSF_TX, 32'h8000_0014);
    @(posedge clk_sys);
    chk("tx watermark", {19'h0, tx_psf_en, tx_psf_wm}, 32'h0000_1014);
    wr(`OFF_CTRL, 32'h0000_0000);
    wr(`OFF_CTRL, 32'h0000_0002);
    wr(`OFF_CTRL, 32'h0000_000a);
    @(posedge clk_sys);
    chk("loopback", loopback, 32'h0000_0001);
    wr(`OFF_TXQ, 32'h0000_0200);
    wr(`OFF_CTRL, 32'h0000_020a);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do
      begin
        @(posedge clk_sys);
        n++;
      end
      while (!(tx_out.valid === 1'b1 && tx_ready === 1'b1) && n < 200);
      chk("tx word", tx_out.data, 32'hcafe_0001 + k);
      chk("tx last", tx_out.last, k);
    end
    wait_bit(32'h81, 31);
    chk("tx used", m(32'h81), 32'hc000_8008);
    rd(`OFF_TXQ, r);
    chk("tx pointer wrap", r, 32'h0000_0200);
    for (n = 0; n < 20; n++)
    begin
      rd(`OFF_STAT, r);
      if (r[2] === 1'b0)
        break;
    end
    chk("tx go cleared", r[2], 32'h0000_0000);
    $display("test tx done");
  endtask : t_tx
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_rx_two();
    t_rx_owned();
    t_rx_strip();
    t_tx();
    report_and_stop();
  end
endmodule : eth_bd_dma_test
bind eth_bd_dma eth_bd_dma_chk i_eth_bd_dma_chk (.clk_sys(clk_sys), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .haddr(haddr), .htrans(htrans), .hready(hready), .hsize(hsize),
  .hburst(hburst), .rx_in(rx_in), .rx_ready(rx_ready), .tx_out(tx_out),
  .tx_ready(tx_ready), .loopback(loopback));
`default_nettype wire
